/* File: rtl/tcis_edge_sync.sv */
`timescale 1ns/1ps
// ==========================================================
// Two-stage synchroniser with rising edge output
module tcis_edge_sync
   import tcis_pkg::*;
(
   input wire logic i_clk_sys, // System clock
   input wire logic i_rst, // Synchronous reset
   input wire logic i_level, // Asynchronous level
   output logic o_rise // One-cycle pulse on rising edge
);
   logic meta_reg;
   logic sync_reg;
   logic prev_reg;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         prev_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= i_level;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   assign o_rise = sync_reg & ~prev_reg;
endmodule

/* File: rtl/tcis_pkg.sv */
package tcis_pkg;

   // ==========================================================
   // Register map
   localparam logic [11:0] TCIS_ADDR_TIMING_CONTROL = 12'h002;
   localparam logic [11:0] TCIS_ADDR_INT_STATUS = 12'h004;
   localparam logic [11:0] TCIS_ADDR_INT_ENABLE = 12'h005;

   localparam logic [7:0] TCIS_TC_RESET = 8'h20;
   localparam logic [7:0] TCIS_INTERRUPT_STATUS_RESET = 8'h00;
   localparam logic [7:0] TCIS_INTERRUPT_ENABLE_RESET = 8'h00;

   // ==========================================================
   // Timing control fields
   localparam int TCIS_WATCHDOG_ENABLE_BIT = 7;
   localparam int TCIS_OUT_FRAME_FORMAT_BIT = 6;
   localparam int TCIS_CLOCK_REF_HI = 5;
   localparam int TCIS_CLOCK_REF_LO = 4;
   localparam int TCIS_HMVIP_BIT = 3;
   localparam int TCIS_PLL_ENABLE_BIT = 2;
   localparam int TCIS_PLL_ROLE_BIT = 1;
   localparam int TCIS_PLL_CLOCK_SOURCE_BIT = 0;

   localparam logic [1:0] TCIS_REF_4MHZ = 2'h0;
   localparam logic [1:0] TCIS_REF_8MHZ_FRAMED = 2'h1;
   localparam logic [1:0] TCIS_REF_8MHZ_UNFRAMED = 2'h2;
   localparam logic [1:0] TCIS_REF_16MHZ = 2'h3;

   // ==========================================================
   // Interrupt status fields
   localparam int TCIS_DCH_RX_FIFO_ERR_FLAG = 7;
   localparam int TCIS_DCH_RX_LEVEL_FLAG = 6;
   localparam int TCIS_DCH_TX_FLAG = 5;
   localparam int TCIS_FSK_TX_EMPTY_FLAG = 4;
   localparam int TCIS_ENERGY_B_FLAG = 3;
   localparam int TCIS_ENERGY_A_FLAG = 2;
   localparam int TCIS_CONF_OVERFLOW_FLAG = 1;
   localparam int TCIS_CLOCK_LOSS_FLAG = 0;

   // ==========================================================
   // Watchdog: 8 MHz tick lost for this long counts as clock loss
   localparam int TCIS_WATCHDOG_TIMEOUT_NS = 1000;
   localparam int TCIS_CLK_PERIOD_NS = 10;
   localparam int TCIS_WATCHDOG_CYCLES = TCIS_WATCHDOG_TIMEOUT_NS / TCIS_CLK_PERIOD_NS;

endpackage

/* File: rtl/tcis_top.sv */
`timescale 1ns/1ps
// How it works
// - Timing control at 0x002, resets 0x20
// - Bit 7 enables clock-loss watchdog interrupt
// - Bit 6 picks outgoing frame pulse format
// - Outgoing format independent of incoming format
// - Bits 5-4 select input clock reference
// - 4 MHz reference needs PLL, PLL clock
// - Internal clock always at least 8 MHz
// - Unframed 8 MHz: ignore frame, generate pulses
// - Bit 3 HMVIP alignment only with 16 MHz
// - Bit 2 enables PLL and its output
// - Bit 1 picks PLL master or slave
// - Bit 0 routes stream clocks from PLL
// - 4 MHz reference: expansion timing from PLL
// - Status at 0x004, read-only, flag layout
// - Bit 6 flags receive length or level
// - Bit 5 flags transmit FIFO or done
// - Status read returns flags, then clears
// - Masked sources set status, no interrupt
// - Conference overflow re-arms only after read
module tcis_top
   import tcis_pkg::*;
#(
   parameter int WATCHDOG_CYCLES = TCIS_WATCHDOG_CYCLES
)
(
   input wire logic i_clk_sys, // System clock, 100 MHz
   input wire logic i_rst, // Synchronous reset, active high
   input wire logic [11:0] i_addr, // Register address
   input wire logic i_wr, // Write strobe, one cycle
   input wire logic i_rd, // Read strobe, one cycle
   input wire logic [7:0] i_wdata, // Write data
   output logic [7:0] o_rdata, // Read data, registered
   output logic o_irq_n, // Interrupt, active low
   input wire logic i_ref_8mhz_clk, // 8 MHz input clock for watchdog
   input wire logic i_frame_in, // Incoming frame pulse
   input wire logic i_dch_rx_fifo_err, // Event pulses from sources
   input wire logic i_dch_rx_msg_len, // Receive length reached
   input wire logic i_dch_rx_fifo_level, // Receive FIFO trigger reached
   input wire logic i_msg_length_mode, // Receiver in message-length mode
   input wire logic i_dch_tx_empty, // Transmit FIFO empty
   input wire logic i_dch_tx_3q_empty, // Transmit FIFO 3/4 empty
   input wire logic i_dch_tx_done, // Transmission complete
   input wire logic i_fsk_tx_empty, // FSK memory empty or end
   input wire logic i_energy_b, // Energy detect B
   input wire logic i_energy_a, // Energy detect A
   input wire logic i_conf_overflow, // Conference accumulator overflow
   output logic [1:0] o_clock_ref_select, // Selected reference
   output logic o_pll_enable, // PLL running
   output logic o_pll_master, // PLL in master role
   output logic o_pll_clk_out_en, // PLL clock output enable
   output logic o_stream_clk_from_pll, // Local/2M/4M timing from PLL
   output logic o_exp_clk_from_pll, // Expansion timing from PLL
   output logic o_int_clk_from_pll, // 8.192 MHz internal from PLL
   output logic o_ref_invalid, // 4 MHz chosen with PLL off
   output logic o_out_frame_gci, // Outgoing frames GCI format
   output logic o_clk_out_invert, // Invert 4 MHz out and 8 MHz clocks
   output logic o_hmvip_align, // HMVIP frame alignment active
   output logic o_use_frame_in, // Incoming frame pulse honoured
   output logic o_gen_frame_out, // Device generates frame outputs
   output logic o_frame_in_gated // Frame pulse passed on
);
   logic [7:0] timing_control_reg;
   logic [7:0] interrupt_status_reg;
   logic [7:0] interrupt_enable_reg;
   logic [7:0] status_set;
   logic [7:0] rdata_next;
   logic ref_tick;
   logic [$clog2(WATCHDOG_CYCLES+1)-1:0] wd_count_reg;
   logic wd_lost_reg;
   logic clk_lost_event;
   logic rd_status;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      hit = (a == b);
   endfunction

   assign rd_status = i_rd & hit(i_addr, TCIS_ADDR_INT_STATUS);

   // ==========================================================
   // Register writes
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         timing_control_reg <= TCIS_TC_RESET;
      else if (i_wr & hit(i_addr, TCIS_ADDR_TIMING_CONTROL))
         timing_control_reg <= i_wdata;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         interrupt_enable_reg <= TCIS_INTERRUPT_ENABLE_RESET;
      else if (i_wr & hit(i_addr, TCIS_ADDR_INT_ENABLE))
         interrupt_enable_reg <= i_wdata;
   end

   // ==========================================================
   // Read data; unmapped addresses read zero
   always_comb
   begin
      rdata_next = 8'h00;
      case (i_addr)
         TCIS_ADDR_TIMING_CONTROL: rdata_next = timing_control_reg;
         TCIS_ADDR_INT_STATUS: rdata_next = interrupt_status_reg;
         TCIS_ADDR_INT_ENABLE: rdata_next = interrupt_enable_reg;
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_rdata <= 8'h00;
      else if (i_rd)
         o_rdata <= rdata_next;
   end

   // ==========================================================
   // Clock watchdog on the 8 MHz input
   tcis_edge_sync u_ref_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_level(i_ref_8mhz_clk),
      .o_rise(ref_tick)
   );

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || !timing_control_reg[TCIS_WATCHDOG_ENABLE_BIT] || ref_tick)
         wd_count_reg <= '0;
      else if (wd_count_reg != ($clog2(WATCHDOG_CYCLES+1))'(WATCHDOG_CYCLES))
         wd_count_reg <= wd_count_reg + 1'b1;
   end

   // Flag once per loss, not every cycle it persists
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || ref_tick || !timing_control_reg[TCIS_WATCHDOG_ENABLE_BIT])
         wd_lost_reg <= 1'b0;
      else if (clk_lost_event)
         wd_lost_reg <= 1'b1;
   end

   assign clk_lost_event = !wd_lost_reg && timing_control_reg[TCIS_WATCHDOG_ENABLE_BIT]
      && (wd_count_reg == ($clog2(WATCHDOG_CYCLES+1))'(WATCHDOG_CYCLES));

   // ==========================================================
   // Interrupt status
   always_comb
   begin
      status_set = 8'h00;
      status_set[TCIS_DCH_RX_FIFO_ERR_FLAG] = i_dch_rx_fifo_err;
      status_set[TCIS_DCH_RX_LEVEL_FLAG] = i_msg_length_mode ? i_dch_rx_msg_len : i_dch_rx_fifo_level;
      status_set[TCIS_DCH_TX_FLAG] = i_dch_tx_empty | i_dch_tx_3q_empty | i_dch_tx_done;
      status_set[TCIS_FSK_TX_EMPTY_FLAG] = i_fsk_tx_empty;
      status_set[TCIS_ENERGY_B_FLAG] = i_energy_b;
      status_set[TCIS_ENERGY_A_FLAG] = i_energy_a;
      status_set[TCIS_CONF_OVERFLOW_FLAG] = i_conf_overflow;
      status_set[TCIS_CLOCK_LOSS_FLAG] = clk_lost_event;
   end

   // Set beats read-clear so no event is lost; a set bit holds,
   // so repeat conference overflows add nothing until read
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         interrupt_status_reg <= TCIS_INTERRUPT_STATUS_RESET;
      else if (rd_status)
         interrupt_status_reg <= status_set;
      else
         interrupt_status_reg <= interrupt_status_reg | status_set;
   end

   // Masked flags still recorded above, only gated here
   assign o_irq_n = ~|(interrupt_status_reg & interrupt_enable_reg);

   // ==========================================================
   // Clock mode decode
   assign o_clock_ref_select = timing_control_reg[TCIS_CLOCK_REF_HI:TCIS_CLOCK_REF_LO];
   assign o_pll_enable = timing_control_reg[TCIS_PLL_ENABLE_BIT];
   assign o_pll_clk_out_en = timing_control_reg[TCIS_PLL_ENABLE_BIT];
   assign o_pll_master = o_pll_enable & timing_control_reg[TCIS_PLL_ROLE_BIT];
   assign o_ref_invalid = (o_clock_ref_select == TCIS_REF_4MHZ) & ~o_pll_enable;
   // Only the 4 MHz reference is below 8 MHz, so only it needs the PLL
   assign o_int_clk_from_pll = (o_clock_ref_select == TCIS_REF_4MHZ) & o_pll_enable;
   assign o_stream_clk_from_pll = o_pll_enable & timing_control_reg[TCIS_PLL_CLOCK_SOURCE_BIT];
   assign o_exp_clk_from_pll = o_stream_clk_from_pll | o_int_clk_from_pll;
   assign o_out_frame_gci = timing_control_reg[TCIS_OUT_FRAME_FORMAT_BIT];
   assign o_clk_out_invert = timing_control_reg[TCIS_OUT_FRAME_FORMAT_BIT];
   assign o_hmvip_align = (o_clock_ref_select == TCIS_REF_16MHZ) & timing_control_reg[TCIS_HMVIP_BIT];
   assign o_use_frame_in = (o_clock_ref_select != TCIS_REF_8MHZ_UNFRAMED);
   assign o_gen_frame_out = ~o_use_frame_in;
   assign o_frame_in_gated = i_frame_in & o_use_frame_in;
endmodule

/* File: verif/tcis_cpu_model.sv */
`timescale 1ns/1ps
module tcis_cpu_model (
   input wire logic i_clk_sys, // System clock
   input wire logic [7:0] i_rdata, // Read data from device
   output logic [11:0] o_addr, // Register address
   output logic o_wr, // Write strobe
   output logic o_rd, // Read strobe
   output logic [7:0] o_wdata // Write data
);
   initial
   begin
      o_addr = 12'h000;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge i_clk_sys);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_clk_sys);
      o_wr = 1'b0;
      o_wdata = ~d; // Released lines must not keep the old value
   endtask
   // Status is polled, never interrupt-driven only
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      @(negedge i_clk_sys);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_clk_sys);
      o_rd = 1'b0;
      d = i_rdata;
   endtask
endmodule

/* File: verif/tcis_props.sv */
`timescale 1ns/1ps
module tcis_props (
   input wire logic i_clk_sys, i_rst, i_rd, i_wr, i_energy_a, i_frame_in, // Clock, reset, strobes, inputs
   input wire logic [11:0] i_addr, // Register address
   input wire logic [7:0] i_wdata, o_rdata, // Write and read data
   input wire logic [1:0] o_clock_ref_select, // Reference select
   input wire logic o_pll_enable, o_pll_master, o_stream_clk_from_pll, o_exp_clk_from_pll, // PLL decode
   input wire logic o_int_clk_from_pll, o_ref_invalid, o_out_frame_gci, o_clk_out_invert, // Clock decode
   input wire logic o_hmvip_align, o_use_frame_in, o_gen_frame_out, o_frame_in_gated // Frame decode
);
   // ==========================================================
   // Properties
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   AST_TC_WRITE: assert property (i_wr && i_addr == 12'h002 |=>
      o_clock_ref_select == $past(i_wdata[5:4]) && o_pll_enable == $past(i_wdata[2])) else $error("TC write lost");
   AST_GCI_INV: assert property (i_wr && i_addr == 12'h002 |=>
      o_out_frame_gci == $past(i_wdata[6]) && o_clk_out_invert == o_out_frame_gci) else $error("Format bit wrong");
   AST_HMVIP: assert property (i_wr && i_addr == 12'h002 |=>
      o_hmvip_align == ($past(i_wdata[5:4]) == 2'h3 && $past(i_wdata[3]))) else $error("Alignment wrong");
   AST_REF_INVALID: assert property (o_ref_invalid == (o_clock_ref_select == 2'h0 && !o_pll_enable))
      else $error("Invalid flag wrong");
   AST_INT_PLL: assert property (o_int_clk_from_pll == (o_clock_ref_select == 2'h0 && o_pll_enable))
      else $error("Internal clock source wrong");
   AST_EXP_PLL: assert property (o_exp_clk_from_pll == (o_stream_clk_from_pll || o_int_clk_from_pll))
      else $error("Expansion source wrong");
   AST_PLL_ROLE: assert property (o_pll_master || o_stream_clk_from_pll |-> o_pll_enable)
      else $error("PLL role without PLL");
   AST_FRAME_GEN: assert property (o_gen_frame_out == (o_clock_ref_select == 2'h2) &&
      o_use_frame_in != o_gen_frame_out && o_frame_in_gated == (i_frame_in && o_use_frame_in)) else $error("Frame gating");
   AST_RD_EVENT: assert property (i_energy_a ##1 (i_rd && i_addr == 12'h004) |=> o_rdata[2])
      else $error("Event not read back");
   AST_RDATA_HOLD: assert property (!i_rd |=> $stable(o_rdata))
      else $error("Read data moved");
   COV_READ: cover property (i_rd && i_addr == 12'h004 ##1 o_rdata != 8'h00);
   COV_HMVIP: cover property (o_hmvip_align);
   COV_INVALID: cover property (o_ref_invalid);
endmodule

bind tcis_top tcis_props u_props (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_rd(i_rd), .i_wr(i_wr),
   .i_energy_a(i_energy_a), .i_frame_in(i_frame_in), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
   .o_clock_ref_select(o_clock_ref_select), .o_pll_enable(o_pll_enable), .o_pll_master(o_pll_master),
   .o_stream_clk_from_pll(o_stream_clk_from_pll), .o_exp_clk_from_pll(o_exp_clk_from_pll),
   .o_int_clk_from_pll(o_int_clk_from_pll), .o_ref_invalid(o_ref_invalid), .o_out_frame_gci(o_out_frame_gci),
   .o_clk_out_invert(o_clk_out_invert), .o_hmvip_align(o_hmvip_align), .o_use_frame_in(o_use_frame_in),
   .o_gen_frame_out(o_gen_frame_out), .o_frame_in_gated(o_frame_in_gated));

/* File: verif/tcis_top_tb.sv */
`timescale 1ns/1ps
module tcis_top_tb
   import tcis_pkg::*;
;
   typedef struct packed {logic [7:0] tc; logic [13:0] exp;} tcis_row_t;
   localparam tcis_row_t ROWS [6] = '{'{8'h00, 14'b00_000000_1000_10}, '{8'h07, 14'b00_111111_0000_10},
      '{8'h5C, 14'b01_101000_0110_10}, '{8'h39, 14'b11_000000_0001_10}, '{8'h2E, 14'b10_111000_0000_01},
      '{8'hB5, 14'b11_101110_0000_10}};
   localparam logic [7:0] EXPV [11] = '{8'h80, 8'h40, 8'h40, 8'h20, 8'h20, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h00};
   logic i_clk_sys, i_rst, i_frame_in, i_ref_8mhz_clk, ref_run, i_msg_length_mode, i_wr, i_rd, o_irq_n, gated;
   logic [9:0] ev;
   logic [11:0] i_addr;
   logic [7:0] i_wdata, o_rdata, rdv;
   logic [13:0] dec;
   int n_errors, cmp_count;
   tcis_cpu_model cpu (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr), .o_rd(i_rd),
      .o_wdata(i_wdata));
   tcis_top #(.WATCHDOG_CYCLES(20)) dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr), .i_wr(i_wr),
      .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq_n(o_irq_n), .i_ref_8mhz_clk(i_ref_8mhz_clk),
      .i_frame_in(i_frame_in), .i_dch_rx_fifo_err(ev[0]), .i_dch_rx_msg_len(ev[1]), .i_dch_rx_fifo_level(ev[2]),
      .i_msg_length_mode(i_msg_length_mode), .i_dch_tx_empty(ev[3]), .i_dch_tx_3q_empty(ev[4]),
      .i_dch_tx_done(ev[5]), .i_fsk_tx_empty(ev[6]), .i_energy_b(ev[7]), .i_energy_a(ev[8]),
      .i_conf_overflow(ev[9]), .o_clock_ref_select(dec[13:12]), .o_pll_enable(dec[11]), .o_pll_master(dec[10]),
      .o_pll_clk_out_en(dec[9]), .o_stream_clk_from_pll(dec[8]), .o_exp_clk_from_pll(dec[7]),
      .o_int_clk_from_pll(dec[6]), .o_ref_invalid(dec[5]), .o_out_frame_gci(dec[4]), .o_clk_out_invert(dec[3]),
      .o_hmvip_align(dec[2]), .o_use_frame_in(dec[1]), .o_gen_frame_out(dec[0]), .o_frame_in_gated(gated));
   // ==========================================================
   // Clocks and helpers
   initial
   begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   always #62 if (ref_run) i_ref_8mhz_clk = ~i_ref_8mhz_clk;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic pulse(input int k);
      @(negedge i_clk_sys);
      ev = 10'h001 << k;
      @(negedge i_clk_sys);
      ev = 10'h000;
   endtask
   task automatic close_out();
      $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      #100000;
      n_errors++;
      close_out();
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      i_rst = 1'b1;
      ev = 10'h000;
      i_frame_in = 1'b1;
      ref_run = 1'b1;
      i_ref_8mhz_clk = 1'b0;
      i_msg_length_mode = 1'b1;
      repeat (20) @(negedge i_clk_sys);
      i_rst = 1'b0;
      chk({o_irq_n, dec[0]}, 16'h0003);
      cpu.rd(TCIS_ADDR_TIMING_CONTROL, rdv);
      chk(rdv, 16'h0020);
      cpu.rd(12'h0F0, rdv);
      chk(rdv, 16'h0000);
      for (int r = 0; r < 6; r++)
      begin
         // A low frame input in the first row proves the gate is an AND
         i_frame_in = (r != 0);
         cpu.wr(TCIS_ADDR_TIMING_CONTROL, ROWS[r].tc);
         cpu.rd(TCIS_ADDR_TIMING_CONTROL, rdv);
         chk(rdv, ROWS[r].tc);
         chk({dec, gated}, {ROWS[r].exp, ROWS[r].exp[1] & (r != 0)});
      end
      cpu.wr(TCIS_ADDR_INT_STATUS, 8'hFF);
      cpu.rd(TCIS_ADDR_INT_STATUS, rdv);
      chk(rdv, 16'h0000);
      cpu.wr(TCIS_ADDR_INT_ENABLE, 8'hFF);
      for (int k = 0; k < 11; k++)
      begin
         i_msg_length_mode = (k != 2);
         pulse((k == 10) ? 2 : k);
         chk(o_irq_n, EXPV[k] == 8'h00);
         cpu.rd(TCIS_ADDR_INT_STATUS, rdv);
         chk(rdv, EXPV[k]);
         chk(o_irq_n, 16'h0001);
      end
      cpu.wr(TCIS_ADDR_INT_ENABLE, 8'h04);
      pulse(7);
      chk(o_irq_n, 16'h0001);
      pulse(8);
      chk(o_irq_n, 16'h0000);
      cpu.rd(TCIS_ADDR_INT_STATUS, rdv);
      chk(rdv, 16'h000C);
      cpu.wr(TCIS_ADDR_INT_ENABLE, 8'h02);
      pulse(9);
      pulse(9);
      cpu.rd(TCIS_ADDR_INT_STATUS, rdv);
      chk({o_irq_n, rdv}, 16'h0102);
      fork
         cpu.rd(TCIS_ADDR_INT_STATUS, rdv);
         pulse(8);
      join
      chk(rdv, 16'h0000);
      cpu.rd(TCIS_ADDR_INT_STATUS, rdv);
      chk(rdv, 16'h0004);
      // Read one cycle behind the event must already see it
      fork
         pulse(8);
         begin
            @(negedge i_clk_sys);
            cpu.rd(TCIS_ADDR_INT_STATUS, rdv);
         end
      join
      chk(rdv, 16'h0004);
      // Watchdog off: a dead reference must stay silent
      cpu.wr(TCIS_ADDR_TIMING_CONTROL, 8'h20);
      cpu.wr(TCIS_ADDR_INT_ENABLE, 8'h01);
      ref_run = 1'b0;
      repeat (40) @(negedge i_clk_sys);
      chk(o_irq_n, 16'h0001);
      cpu.wr(TCIS_ADDR_TIMING_CONTROL, 8'hA0);
      for (int w = 0; w < 60 && o_irq_n !== 1'b0; w++) @(negedge i_clk_sys);
      chk(o_irq_n, 16'h0000);
      cpu.rd(TCIS_ADDR_INT_STATUS, rdv);
      chk(rdv, 16'h0001);
      ref_run = 1'b1;
      // Mid-run reset must restore timing control and interrupt enable
      cpu.wr(TCIS_ADDR_INT_ENABLE, 8'hFF);
      pulse(0);
      chk(o_irq_n, 16'h0000);
      i_rst = 1'b1;
      repeat (2) @(negedge i_clk_sys);
      i_rst = 1'b0;
      chk(o_irq_n, 16'h0001);
      cpu.rd(TCIS_ADDR_TIMING_CONTROL, rdv);
      chk(rdv, 16'h0020);
      // Enable register is back to zero, so the event stays masked
      pulse(0);
      chk(o_irq_n, 16'h0001);
      cpu.rd(TCIS_ADDR_INT_STATUS, rdv);
      chk(rdv, 16'h0080);
      close_out();
   end
endmodule
